// file: hw/ifc_cfg_regs.v
`include "ifc_cfg_map.vh"

module ifc_cfg_regs #(
   parameter DATA_W = 10
) (
   input  wire              i_clk,
   input  wire              i_rst,
   input  wire              i_sclk,
   input  wire              i_ce,
   input  wire              i_sdi,
   output reg               o_sdo,
   output reg               o_sdo_oe,
   input  wire              i_line_start_strobe,
   input  wire              i_pixel_tick,
   input  wire              i_blk_valid,
   input  wire [7:0]        i_blk_offset_a,
   input  wire [7:0]        i_blk_offset_b,
   input  wire [7:0]        i_blk_offset_c,
   input  wire [7:0]        i_blk_offset_d,
   input  wire [DATA_W-1:0] i_adc_data,
   input  wire [DATA_W-1:0] i_offset_error,
   output reg  [DATA_W-1:0] o_out_data,
   output reg  [1:0]        o_pixel_sel,
   output reg  [7:0]        o_offset_a,
   output reg  [7:0]        o_offset_b,
   output reg  [7:0]        o_offset_c,
   output reg  [7:0]        o_offset_d,
   output reg  [7:0]        o_black_level_target,
   output reg  [2:0]        o_integ_shift,
   output reg               o_auto_black_en,
   output reg               o_strobe_rising,
   output reg               o_cds_select,
   output reg               o_analog_power_down,
   output reg  [1:0]        o_monitor_select,
   output reg               o_monitor_enable,
   output reg               o_adc_ref_active,
   output reg               o_dac_ref_active,
   output reg  [7:0]        o_front_bias,
   output reg  [7:0]        o_back_bias
);

   localparam ST_IDLE = 2'b00;
   localparam ST_CMD  = 2'b01;
   localparam ST_WDAT = 2'b10;
   localparam ST_RDAT = 2'b11;

   // Pin inputs pass two flops, each reset to its pin's idle level
   reg        sclk_prev_q;
   reg        lstart_prev_q;
   wire       s_sclk;
   wire       s_ce;
   wire       s_sdi;
   wire       s_lstart;
   wire       s_pix;
   wire       sclk_rise = s_sclk & ~sclk_prev_q;
   wire       sclk_fall = ~s_sclk & sclk_prev_q;

   ifc_cfg_sync #(
      .RST_VAL (1'b0)
   ) sclk_sync_inst (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_d   (i_sclk),
      .o_q   (s_sclk)
   );

   // Chip enable idles high, so no false frame follows reset
   ifc_cfg_sync #(
      .RST_VAL (1'b1)
   ) ce_sync_inst (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_d   (i_ce),
      .o_q   (s_ce)
   );

   ifc_cfg_sync #(
      .RST_VAL (1'b0)
   ) sdi_sync_inst (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_d   (i_sdi),
      .o_q   (s_sdi)
   );

   ifc_cfg_sync #(
      .RST_VAL (1'b0)
   ) lstart_sync_inst (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_d   (i_line_start_strobe),
      .o_q   (s_lstart)
   );

   ifc_cfg_sync #(
      .RST_VAL (1'b0)
   ) pix_sync_inst (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_d   (i_pixel_tick),
      .o_q   (s_pix)
   );

   always @(posedge i_clk) begin
      if (i_rst) begin
         sclk_prev_q <= 1'b0;
         lstart_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= s_sclk;
         lstart_prev_q <= s_lstart;
      end
   end

   // Register bank
   reg  [7:0] ofs_q [0:3];
   reg  [7:0] map_even_q;
   reg  [7:0] map_odd_q;
   reg  [7:0] pat_len_q;
   reg  [7:0] blk_tgt_q;
   reg  [7:0] main_ctl_q;
   reg  [7:0] mon_ctl_q;
   reg  [7:0] front_bias_q;
   reg  [7:0] back_bias_q;

   // Serial engine: R/W bit, 3 reserved/upper addr bits, 4 addr bits, 8 data, MSB first
   reg  [1:0] st_q;
   reg  [3:0] bit_cnt_q;
   reg  [7:0] shift_q;
   reg  [3:0] addr_q;
   reg        wr_stb_q;
   reg  [7:0] wr_data_q;
   reg  [7:0] rd_val;
   integer    k;

   always @* begin
      case (addr_q)
         `IFC_ADDR_OFS_A:      rd_val = ofs_q[0];
         `IFC_ADDR_OFS_B:      rd_val = ofs_q[1];
         `IFC_ADDR_OFS_C:      rd_val = ofs_q[2];
         `IFC_ADDR_OFS_D:      rd_val = ofs_q[3];
         `IFC_ADDR_MAP_EVEN:   rd_val = map_even_q;
         `IFC_ADDR_MAP_ODD:    rd_val = map_odd_q;
         `IFC_ADDR_PAT_LEN:    rd_val = pat_len_q;
         `IFC_ADDR_BLK_TGT:    rd_val = blk_tgt_q;
         `IFC_ADDR_MAIN_CTL:   rd_val = main_ctl_q;
         `IFC_ADDR_MON_CTL:    rd_val = mon_ctl_q;
         `IFC_ADDR_FRONT_BIAS: rd_val = front_bias_q;
         `IFC_ADDR_BACK_BIAS:  rd_val = back_bias_q;
         default:              rd_val = 8'h00;
      endcase
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         st_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         addr_q <= 4'h0;
         wr_stb_q <= 1'b0;
         wr_data_q <= 8'h00;
         o_sdo <= 1'b0;
         o_sdo_oe <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         if (s_ce) begin
            st_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            o_sdo_oe <= 1'b0;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  st_q <= ST_CMD;
                  bit_cnt_q <= 4'h0;
               end
               ST_CMD: begin
                  if (sclk_rise) begin
                     shift_q <= {shift_q[6:0], s_sdi};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     if (bit_cnt_q == 4'h7) begin
                        addr_q <= {shift_q[2:0], s_sdi};
                        bit_cnt_q <= 4'h0;
                        st_q <= shift_q[6] ? ST_RDAT : ST_WDAT;
                     end
                  end
               end
               ST_WDAT: begin
                  if (sclk_rise) begin
                     shift_q <= {shift_q[6:0], s_sdi};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     if (bit_cnt_q == 4'h7) begin
                        wr_data_q <= {shift_q[6:0], s_sdi};
                        wr_stb_q <= 1'b1;
                        st_q <= ST_IDLE;
                     end
                  end
               end
               ST_RDAT: begin
                  if (sclk_fall) begin
                     o_sdo <= rd_val[3'd7 - bit_cnt_q[2:0]];
                     o_sdo_oe <= main_ctl_q[`IFC_CTL_SO_EN];
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     if (bit_cnt_q == 4'h8) begin
                        o_sdo_oe <= 1'b0;
                        st_q <= ST_IDLE;
                     end
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   wire auto_en = main_ctl_q[`IFC_CTL_AUTO_BLK];

   always @(posedge i_clk) begin
      if (i_rst) begin
         for (k = 0; k < 4; k = k + 1)
            ofs_q[k] <= `IFC_RST_OFS;
         map_even_q <= `IFC_RST_MAP;
         map_odd_q <= `IFC_RST_MAP;
         pat_len_q <= `IFC_RST_PAT_LEN;
         blk_tgt_q <= `IFC_RST_BLK_TGT;
         main_ctl_q <= `IFC_RST_MAIN_CTL;
         mon_ctl_q <= `IFC_RST_MON_CTL;
         front_bias_q <= `IFC_RST_FRONT_BIAS;
         back_bias_q <= `IFC_RST_BACK_BIAS;
      end else begin
         if (auto_en && i_blk_valid) begin
            ofs_q[0] <= i_blk_offset_a;
            ofs_q[1] <= i_blk_offset_b;
            ofs_q[2] <= i_blk_offset_c;
            ofs_q[3] <= i_blk_offset_d;
         end
         if (wr_stb_q) begin
            case (addr_q)
               `IFC_ADDR_OFS_A: if (!auto_en) ofs_q[0] <= wr_data_q;
               `IFC_ADDR_OFS_B: if (!auto_en) ofs_q[1] <= wr_data_q;
               `IFC_ADDR_OFS_C: if (!auto_en) ofs_q[2] <= wr_data_q;
               `IFC_ADDR_OFS_D: if (!auto_en) ofs_q[3] <= wr_data_q;
               `IFC_ADDR_MAP_EVEN:   map_even_q <= wr_data_q;
               `IFC_ADDR_MAP_ODD:    map_odd_q <= wr_data_q;
               `IFC_ADDR_PAT_LEN:    pat_len_q <= wr_data_q & `IFC_MASK_PAT_LEN;
               `IFC_ADDR_BLK_TGT:    blk_tgt_q <= wr_data_q;
               `IFC_ADDR_MAIN_CTL:   main_ctl_q <= wr_data_q;
               `IFC_ADDR_MON_CTL:    mon_ctl_q <= wr_data_q & `IFC_MASK_MON_CTL;
               `IFC_ADDR_FRONT_BIAS: front_bias_q <= wr_data_q;
               `IFC_ADDR_BACK_BIAS:  back_bias_q <= wr_data_q;
               default: ;
            endcase
         end
      end
   end

   // Colour map sequencer
   reg        line_odd_q;
   reg        active_q;
   reg  [1:0] pos_q;
   wire [7:0] cur_map = line_odd_q ? map_odd_q : map_even_q;
   wire [1:0] cur_len = line_odd_q ? pat_len_q[3:2] : pat_len_q[1:0];

   always @(posedge i_clk) begin
      if (i_rst) begin
         line_odd_q <= 1'b1;
         active_q <= 1'b0;
         pos_q <= 2'b00;
      end else begin
         if (s_lstart && !lstart_prev_q) begin
            line_odd_q <= ~line_odd_q;
            active_q <= 1'b1;
            pos_q <= 2'b00;
         end else if (!s_lstart) begin
            active_q <= 1'b0;
         end else if (active_q && s_pix) begin
            pos_q <= (pos_q == cur_len) ? 2'b00 : pos_q + 2'b01;
         end
      end
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         o_pixel_sel <= 2'b00;
         o_out_data <= {DATA_W{1'b0}};
         o_offset_a <= 8'h00;
         o_offset_b <= 8'h00;
         o_offset_c <= 8'h00;
         o_offset_d <= 8'h00;
         o_black_level_target <= 8'h00;
         o_integ_shift <= 3'd0;
         o_auto_black_en <= 1'b0;
         o_strobe_rising <= 1'b0;
         o_cds_select <= 1'b0;
         o_analog_power_down <= 1'b0;
         o_monitor_select <= 2'b00;
         o_monitor_enable <= 1'b0;
         o_adc_ref_active <= 1'b0;
         o_dac_ref_active <= 1'b0;
         o_front_bias <= 8'h00;
         o_back_bias <= 8'h00;
      end else begin
         case (pos_q)
            2'd0:    o_pixel_sel <= cur_map[1:0];
            2'd1:    o_pixel_sel <= cur_map[3:2];
            2'd2:    o_pixel_sel <= cur_map[5:4];
            default: o_pixel_sel <= cur_map[7:6];
         endcase
         o_out_data <= main_ctl_q[`IFC_CTL_OFS_OUT] ? i_offset_error : i_adc_data;
         o_offset_a <= ofs_q[0];
         o_offset_b <= ofs_q[1];
         o_offset_c <= ofs_q[2];
         o_offset_d <= ofs_q[3];
         o_black_level_target <= blk_tgt_q;
         case (main_ctl_q[`IFC_CTL_INTEG_HI:`IFC_CTL_INTEG_LO])
            2'b00:   o_integ_shift <= 3'd0;
            2'b01:   o_integ_shift <= 3'd2;
            2'b10:   o_integ_shift <= 3'd3;
            default: o_integ_shift <= 3'd4;
         endcase
         o_auto_black_en <= auto_en;
         o_strobe_rising <= main_ctl_q[`IFC_CTL_STROBE_HI];
         o_cds_select <= main_ctl_q[`IFC_CTL_CDS_EN];
         o_analog_power_down <= main_ctl_q[`IFC_CTL_PWR_DN];
         o_monitor_select <= mon_ctl_q[`IFC_MON_SEL_HI:`IFC_MON_SEL_LO];
         o_monitor_enable <= mon_ctl_q[`IFC_MON_EN];
         o_adc_ref_active <= mon_ctl_q[`IFC_MON_ADC_REF];
         o_dac_ref_active <= ~mon_ctl_q[`IFC_MON_DAC_REF];
         o_front_bias <= front_bias_q;
         o_back_bias <= back_bias_q;
      end
   end

endmodule

// Two-flop synchroniser for one pin
module ifc_cfg_sync #(
   parameter RST_VAL = 1'b0
) (
   input  wire i_clk,
   input  wire i_rst,
   input  wire i_d,
   output wire o_q
);

   reg meta_q;
   reg sync_q;

   assign o_q = sync_q;

   always @(posedge i_clk) begin
      if (i_rst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= i_d;
         sync_q <= meta_q;
      end
   end

endmodule

// file: inc/ifc_cfg_map.vh
`ifndef IFC_CFG_MAP_VH
`define IFC_CFG_MAP_VH

`define IFC_ADDR_OFS_A      4'h4
`define IFC_ADDR_OFS_B      4'h5
`define IFC_ADDR_OFS_C      4'h6
`define IFC_ADDR_OFS_D      4'h7
`define IFC_ADDR_MAP_EVEN   4'h8
`define IFC_ADDR_MAP_ODD    4'h9
`define IFC_ADDR_PAT_LEN    4'hA
`define IFC_ADDR_BLK_TGT    4'hB
`define IFC_ADDR_MAIN_CTL   4'hC
`define IFC_ADDR_MON_CTL    4'hD
`define IFC_ADDR_FRONT_BIAS 4'hE
`define IFC_ADDR_BACK_BIAS  4'hF

`define IFC_RST_OFS         8'h00
`define IFC_RST_MAP         8'h00
`define IFC_RST_PAT_LEN     8'h00
`define IFC_RST_BLK_TGT     8'h10
`define IFC_RST_MAIN_CTL    8'h4E
`define IFC_RST_MON_CTL     8'h00
`define IFC_RST_FRONT_BIAS  8'hAA
`define IFC_RST_BACK_BIAS   8'h5A

`define IFC_MASK_PAT_LEN    8'h0F
`define IFC_MASK_MON_CTL    8'h3B

`define IFC_CTL_OFS_OUT     7
`define IFC_CTL_SO_EN       6
`define IFC_CTL_INTEG_HI    5
`define IFC_CTL_INTEG_LO    4
`define IFC_CTL_AUTO_BLK    3
`define IFC_CTL_STROBE_HI   2
`define IFC_CTL_CDS_EN      1
`define IFC_CTL_PWR_DN      0

`define IFC_MON_SEL_HI      5
`define IFC_MON_SEL_LO      4
`define IFC_MON_EN          3
`define IFC_MON_ADC_REF     1
`define IFC_MON_DAC_REF     0

`endif

// file: dv/ifc_cfg_checker.sv
module ifc_cfg_checker #(
   parameter DATA_W = 10
) (
   input wire              i_clk,
   input wire              i_rst,
   input wire              i_ce,
   input wire              i_blk_valid,
   input wire [7:0]        i_blk_offset_a,
   input wire [7:0]        i_blk_offset_d,
   input wire [DATA_W-1:0] i_adc_data,
   input wire [DATA_W-1:0] i_offset_error,
   input wire [DATA_W-1:0] o_out_data,
   input wire              o_sdo_oe,
   input wire [7:0]        o_offset_a,
   input wire [7:0]        o_offset_d,
   input wire [2:0]        o_integ_shift,
   input wire [7:0]        o_front_bias,
   input wire [7:0]        o_back_bias,
   input wire [7:0]        o_black_level_target,
   input wire              o_dac_ref_active,
   input wire              o_auto_black_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic [2:0] up_q;
   wire        up_ok;
   // Cycles since reset release, saturating, so history checks skip reset
   always_ff @(posedge i_clk) begin
      if (i_rst) up_q <= 3'h0;
      else if (up_q != 3'h4) up_q <= up_q + 3'h1;
   end
   assign up_ok = up_q == 3'h4;
   sequence s_ce_idle;
      i_ce [*6];
   endsequence
   sequence s_loop_load;
      $past(o_auto_black_en) && $past(i_blk_valid, 2);
   endsequence
   reset_values_a: assert property (up_q == 3'h3 |->
      o_front_bias == 8'hAA && o_back_bias == 8'h5A && o_black_level_target == 8'h10
      && o_dac_ref_active && o_auto_black_en && o_offset_a == 8'h00)
      else $error("reset values wrong");
   loop_load_lo_a: assert property ((up_ok and s_loop_load) |->
      o_offset_a == $past(i_blk_offset_a, 2)) else $error("loop offset a not loaded");
   loop_load_hi_a: assert property ((up_ok and s_loop_load) |->
      o_offset_d == $past(i_blk_offset_d, 2)) else $error("loop offset d not loaded");
   offset_lock_lo_a: assert property (up_ok && $past(o_auto_black_en) &&
      !$past(i_blk_valid, 2) |-> $stable(o_offset_a)) else $error("offset a changed");
   offset_lock_hi_a: assert property (up_ok && $past(o_auto_black_en) &&
      !$past(i_blk_valid, 2) |-> $stable(o_offset_d)) else $error("offset d changed");
   data_select_a: assert property (up_ok |-> o_out_data == $past(i_adc_data) ||
      o_out_data == $past(i_offset_error)) else $error("output data source wrong");
   integ_code_a: assert property (o_integ_shift != 3'h1 && o_integ_shift <= 3'h4)
      else $error("integration shift illegal");
   sdo_idle_a: assert property (s_ce_idle |-> !o_sdo_oe)
      else $error("serial output driven while idle");
endmodule

bind ifc_cfg_regs ifc_cfg_checker #(.DATA_W(DATA_W)) chk_inst (.i_clk, .i_rst, .i_ce,
   .i_blk_valid, .i_blk_offset_a, .i_blk_offset_d, .i_adc_data, .i_offset_error,
   .o_out_data, .o_sdo_oe, .o_offset_a, .o_offset_d, .o_integ_shift, .o_front_bias,
   .o_back_bias, .o_black_level_target, .o_dac_ref_active, .o_auto_black_en);

// file: dv/ifc_host_model.sv
module ifc_host_model (
   input  logic i_clk,
   output logic o_sclk,
   output logic o_ce,
   output logic o_sdi,
   input  logic i_sdo,
   input  logic i_sdo_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_sclk = 1'b0;
      o_ce = 1'b1;
      o_sdi = 1'b0;
   end
   // One frame of 16 bits; serial clock rests low between frames
   task automatic xfer(input logic [15:0] cmd, output logic [7:0] rd, output logic seen);
      int i;
      seen = 1'b0;
      rd = 8'h00;
      @(negedge i_clk) o_ce = 1'b0;
      repeat (6) @(negedge i_clk);
      for (i = 15; i >= 0; i--) begin
         o_sdi = cmd[i];
         repeat (6) @(negedge i_clk);
         o_sclk = 1'b1;
         if (i < 8) begin
            rd[i] = i_sdo;
            seen = seen | i_sdo_oe;
         end
         repeat (6) @(negedge i_clk);
         o_sclk = 1'b0;
      end
      repeat (6) @(negedge i_clk);
      o_ce = 1'b1;
      // Stale data must not look valid after the frame
      o_sdi = ~o_sdi;
      repeat (12) @(negedge i_clk);
   endtask
endmodule

// file: dv/test_imager_frontend_config_regs.sv
module test_imager_frontend_config_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic       i_clk = 1'b0;
   logic       i_rst = 1'b1;
   logic       i_line_start_strobe = 1'b0;
   logic       i_pixel_tick = 1'b0;
   logic       i_blk_valid = 1'b0;
   logic [7:0] blk [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
   logic [9:0] i_adc_data = 10'h000;
   logic [9:0] i_offset_error = 10'h000;
   logic [7:0] sh [16];
   int         seed = 86660;
   int         failures = 0;
   int         n_checks = 0;
   wire        sclk, ce, sdi, o_sdo, o_sdo_oe, o_auto_black_en, o_strobe_rising;
   wire        o_cds_select, o_analog_power_down, o_monitor_enable, o_adc_ref_active;
   wire        o_dac_ref_active;
   wire [9:0]  o_out_data;
   wire [1:0]  o_pixel_sel, o_monitor_select;
   wire [2:0]  o_integ_shift;
   wire [7:0]  o_offset_a, o_offset_b, o_offset_c, o_offset_d, o_front_bias, o_back_bias;
   wire [7:0]  o_black_level_target;
   initial forever #50 i_clk = ~i_clk;
   ifc_host_model host_inst (.i_clk(i_clk), .o_sclk(sclk), .o_ce(ce), .o_sdi(sdi),
      .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe));
   ifc_cfg_regs ifc_cfg_regs_inst (.i_clk, .i_rst, .i_sclk(sclk), .i_ce(ce), .i_sdi(sdi),
      .o_sdo, .o_sdo_oe, .i_line_start_strobe, .i_pixel_tick, .i_blk_valid,
      .i_blk_offset_a(blk[0]), .i_blk_offset_b(blk[1]), .i_blk_offset_c(blk[2]),
      .i_blk_offset_d(blk[3]), .i_adc_data, .i_offset_error, .o_out_data, .o_pixel_sel,
      .o_offset_a, .o_offset_b, .o_offset_c, .o_offset_d, .o_black_level_target,
      .o_integ_shift, .o_auto_black_en, .o_strobe_rising, .o_cds_select,
      .o_analog_power_down, .o_monitor_select, .o_monitor_enable, .o_adc_ref_active,
      .o_dac_ref_active, .o_front_bias, .o_back_bias);
   function automatic logic [7:0] rv(input int a);
      rv = a == 11 ? 8'h10 : a == 12 ? 8'h4E : a == 14 ? 8'hAA : a == 15 ? 8'h5A : 8'h00;
   endfunction
   function automatic logic [7:0] msk(input int a, input logic [7:0] d);
      msk = a < 4 ? 8'h00 : a == 10 ? d & 8'h0F : a == 13 ? d & 8'h3B : d;
   endfunction
   function automatic logic [2:0] ish(input logic [1:0] s);
      ish = (s == 2'b00) ? 3'h0 : {1'b0, s} + 3'h1;
   endfunction
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic       s;
      host_inst.xfer({4'h0, a, d}, r, s);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] r;
      logic       s;
      host_inst.xfer({4'h8, a, 8'h00}, r, s);
      chk("readback", 10'(e), 10'(r));
      chk("read_oe", 10'h001, 10'(s));
   endtask
   task automatic conclude;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge i_clk);
      failures++;
      conclude;
   end
   initial begin
      int         a, k, n, ln;
      logic [7:0] d, pl;
      logic [7:0] r;
      logic       s;
      repeat (10) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_clk);
      for (a = 0; a < 16; a++) rdc(a[3:0], rv(a));
      for (n = 0; n < 3; n++) begin
         for (a = 0; a < 16; a++) begin
            if (a < 4 || a > 7) begin
               d = 8'($random(seed));
               // Keep readback and the loop on so offsets stay locked
               if (a == 12) d = d | 8'h48;
               wr(a[3:0], d);
               sh[a] = msk(a, d);
               rdc(a[3:0], sh[a]);
            end
         end
         chk("integ", 10'(ish(sh[12][5:4])), 10'(o_integ_shift));
         chk("ctl", 10'(sh[12][3:0]), 10'({o_auto_black_en, o_strobe_rising,
            o_cds_select, o_analog_power_down}));
         chk("mon", 10'({sh[13][5:3], sh[13][1:0]}), 10'({o_monitor_select,
            o_monitor_enable, o_adc_ref_active, ~o_dac_ref_active}));
         chk("front", 10'(sh[14]), 10'(o_front_bias));
         chk("black", 10'(sh[11]), 10'(o_black_level_target));
         chk("back", 10'(sh[15]), 10'(o_back_bias));
      end
      for (a = 4; a < 8; a++) begin
         wr(a[3:0], 8'h5C);
         rdc(a[3:0], 8'h00);
      end
      for (k = 0; k < 4; k++) blk[k] = 8'($random(seed));
      i_blk_valid = 1'b1;
      @(negedge i_clk);
      i_blk_valid = 1'b0;
      repeat (3) @(negedge i_clk);
      chk("loop_a", 10'(blk[0]), 10'(o_offset_a));
      rdc(4'h7, blk[3]);
      wr(4'hC, 8'h40);
      for (a = 4; a < 8; a++) begin
         sh[a] = 8'($random(seed));
         wr(a[3:0], sh[a]);
         rdc(a[3:0], sh[a]);
      end
      chk("ofs_a", 10'(sh[4]), 10'(o_offset_a));
      chk("ofs_b", 10'(sh[5]), 10'(o_offset_b));
      chk("ofs_c", 10'(sh[6]), 10'(o_offset_c));
      chk("ofs_d", 10'(sh[7]), 10'(o_offset_d));
      for (k = 0; k < 2; k++) begin
         wr(4'hC, k ? 8'hC0 : 8'h40);
         i_adc_data = 10'($random(seed));
         i_offset_error = 10'($random(seed));
         repeat (2) @(negedge i_clk);
         chk("out", k ? i_offset_error : i_adc_data, o_out_data);
      end
      wr(4'hC, 8'h00);
      host_inst.xfer(16'h8C00, r, s);
      chk("sdo_oe", 10'(s), 10'h000);
      wr(4'hC, 8'h40);
      sh[8] = 8'($random(seed));
      sh[9] = 8'($random(seed));
      pl = 8'($random(seed));
      wr(4'h8, sh[8]);
      wr(4'h9, sh[9]);
      wr(4'hA, pl);
      for (n = 0; n < 4; n++) begin
         d = n[0] ? sh[9] : sh[8];
         ln = n[0] ? pl[3:2] + 1 : pl[1:0] + 1;
         i_line_start_strobe = 1'b1;
         repeat (6) @(negedge i_clk);
         for (k = 0; k < 6; k++) begin
            chk("pix", 10'(d[2 * (k % ln) +: 2]), 10'(o_pixel_sel));
            i_pixel_tick = 1'b1;
            @(negedge i_clk);
            i_pixel_tick = 1'b0;
            repeat (5) @(negedge i_clk);
         end
         i_line_start_strobe = 1'b0;
         repeat (6) @(negedge i_clk);
      end
      i_rst = 1'b1;
      repeat (10) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_clk);
      rdc(4'hA, 8'h00);
      rdc(4'hB, 8'h10);
      conclude;
   end
endmodule
